// >>> irk_pkg.sv
// irk_pkg: constants, types and state layout of the infrared key encoder
//
// Contract
// - seven open-drain scan drivers, seven active-low sense inputs held high by pull-ups
// - in stand-by every scan driver conducts to ground
// - sense low starts oscillator, debounce, then drivers are activated one by one
// - single sense lines give 56 codes; lines five plus six extend to 64
// - top drive line seen on the strap selects modulated, else flashed
// - strap pull-down only in stand-by; pull-up replaces it before sensing
// - open strap decodes as sub-system address 0, flashed
// - highest-numbered of drive lines 0 to 5 seen on the strap sets the address
// - drive line n gives sub-system address n plus one
// - address change alone never starts a transmission
// - first scan cycle latches mode, address and command code
// - address sampled only in first scan cycle; later strap changes ignored
// - during multiple key strokes the command code keeps its last single-key value
// - word is toggle high, toggle low, sub-system 2..0, key code MSB first
// - modulated mode puts a fixed reference bit in first toggle position
// - bit value is the spacing between leading edges of pulses or bursts
// - any output pulse is forced low within 1 ms, even if oscillator stalls
// - several keys at once never start a new transmission
// - multiple key condition speeds up scan repetition
// - grounded sense line ignores other keys on it, sends grounded-key code
// - lines five and six on one drive line are one key, codes 56 to 63
// - toggle bits tell the decoder the next word is a new command
// - toggles advance only after minimum release time; fixed during multi-key strokes
// - a started word is always finished even if the key is released
// - base unit 1152 oscillator periods; zero spaced two units, one three
// - modulated carrier cycle 12 oscillator periods, high 4, low 8
package irk_pkg;

   // ************************************************************
   // general sizes and timing
   // ************************************************************
   localparam int NLINES           = 7;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int TOSC_NS          = 2200;
   localparam int OSC_DIV          = TOSC_NS / CLK_PERIOD_NS;
   localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV - 1);
   localparam int LOCKUP_NS        = 1000000;
   localparam int LOCKUP_LIMIT_CYC = LOCKUP_NS / CLK_PERIOD_NS - 1;
   localparam int WORD_DIST_TOSC   = 55296;

   // ************************************************************
   // pulse-distance code, in oscillator periods
   // ************************************************************
   localparam logic [11:0] BASE_UNIT_TICKS = 12'h480;
   localparam logic [11:0] SPACE_ZERO_LAST = 12'(2 * 1152 - 1);
   localparam logic [11:0] SPACE_ONE_LAST  = 12'(3 * 1152 - 1);
   localparam logic [11:0] TX_CNT_MAX      = 12'hFFF;
   localparam logic [11:0] FLASH_PULSE_TICKS = 12'h004;
   localparam logic [3:0]  CARRIER_LAST    = 4'hB;
   localparam logic [3:0]  CARRIER_HIGH    = 4'h4;
   localparam logic [11:0] BURST_TICKS     = 12'(8 * 12);
   localparam logic [3:0]  FINAL_PULSE_IDX = 4'hB;

   // ************************************************************
   // scan timing, in oscillator periods
   // ************************************************************
   localparam logic [7:0]  DEBOUNCE_LAST = 8'h0F;
   localparam logic [7:0]  STEP_LAST     = 8'h03;
   localparam logic [7:0]  GAP_SLOW_LAST = 8'h3F;
   localparam logic [7:0]  GAP_FAST_LAST = 8'h01;
   localparam logic [11:0] REL_TICKS     = 12'h900;
   localparam logic [2:0]  LAST_STEP     = 3'h7;
   localparam logic [2:0]  GND_POS       = 3'h7;

   // ************************************************************
   // key and address coding
   // ************************************************************
   localparam logic [6:0] PAIR_56_MASK   = 7'h60;
   localparam logic [2:0] SENSE_PAIR_IDX = 3'h7;
   localparam logic [2:0] SUB_OPEN       = 3'h7;
   localparam int         MODE_LINE      = 6;
   localparam int         ADDR_LINES     = 6;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {PH_STANDBY, PH_DEBOUNCE, PH_SCAN, PH_GAP} irk_phase_t;

   typedef struct packed {
      logic       modulated;
      logic [2:0] sub;
   } irk_addr_t;

   typedef struct packed {
      logic [1:0] cnt;
      logic [5:0] code;
   } irk_key_t;

   typedef struct packed {
      irk_phase_t  phase;
      logic [7:0]  osc_div;
      logic [7:0]  cnt;
      logic [2:0]  step;
      logic [6:0]  gnd_mask;
      irk_key_t    acc;
      logic [6:0]  strap_seen;
      logic        first_scan;
      irk_addr_t   addr;
      logic        have_key;
      logic [5:0]  key_code;
      logic        multi;
      logic [1:0]  toggle;
      logic [11:0] rel_cnt;
      logic        tx_on;
      logic [16:0] word_cnt;
      logic [3:0]  bit_idx;
      logic [11:0] tx_cnt;
      logic [3:0]  car_ph;
      logic [10:0] word_sh;
      logic        pulse_req;
      logic [6:0]  drv_out;
      logic [6:0]  drv_oe_n;
      logic        strap_pu;
      logic        strap_pd;
      logic        osc_en;
   } irk_state_t;

   typedef struct packed {
      logic [16:0] cnt;
      logic        out;
   } irk_guard_t;

   localparam irk_state_t ST_RESET = '{phase: PH_STANDBY, strap_pd: 1'b1, default: '0};

endpackage

// >>> irk_addr_decode.sv
// irk_addr_decode: strap pattern to transmission mode and sub-system bits
`timescale 1ns/1ps
module irk_addr_decode import irk_pkg::*; (
   // drive lines seen on the strap
   input  wire logic [6:0] seen_i,
   // decoded mode and address
   output irk_addr_t       addr_o
);

   always_comb begin
      addr_o.modulated = seen_i[MODE_LINE];
      addr_o.sub       = SUB_OPEN;
      // later lines override earlier ones; drive n sends bits n (address n+1)
      for (int n = 0; n < ADDR_LINES; n++) begin
         if (seen_i[n]) begin
            addr_o.sub = 3'(n);
         end
      end
   end

endmodule

// >>> irk_lockup_guard.sv
// irk_lockup_guard: limits each output pulse to under one millisecond
`timescale 1ns/1ps
module irk_lockup_guard import irk_pkg::*; #(
   parameter logic [16:0] LIMIT = 17'(LOCKUP_LIMIT_CYC)
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // pulse request and guarded pulse
   input  wire logic req_i,
   output logic      pulse_o
);

   irk_guard_t g_q;
   irk_guard_t g_d;

   // runs on the system clock, so a stalled oscillator cannot hold the led on
   always_comb begin
      g_d = g_q;
      if (!req_i) begin
         g_d.cnt = '0;
         g_d.out = 1'b0;
      end else if (g_q.cnt < LIMIT) begin
         g_d.cnt = g_q.cnt + 17'h00001;
         g_d.out = 1'b1;
      end else begin
         g_d.out = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         g_q <= '0;
      end else begin
         g_q <= g_d;
      end
   end

   assign pulse_o = g_q.out;

endmodule

// >>> irk_encoder.sv
// irk_encoder: key matrix scanner and pulse-distance infrared word encoder
`timescale 1ns/1ps
module irk_encoder import irk_pkg::*; #(
   parameter logic [16:0] WORD_TICKS    = 17'(WORD_DIST_TOSC),
   parameter logic [16:0] LOCKUP_CYCLES = 17'(LOCKUP_LIMIT_CYC)
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // key matrix
   input  wire logic [6:0] key_sense_lines_n_i,
   output logic [6:0]      scan_drive_lines_o,
   output logic [6:0]      scan_drive_lines_oe_n_o,
   // address and mode strap
   input  wire logic       address_mode_strap_i,
   output logic            strap_pull_up_o,
   output logic            strap_pull_down_o,
   // resonator and infrared output
   output logic            resonator_en_o,
   output logic            ir_pattern_out_o,
   // status
   output logic            tx_busy_o,
   output logic            multi_key_o
);

   irk_state_t s_q;
   irk_state_t s_d;
   logic       tick;
   logic [6:0] active;
   logic [6:0] lines;
   logic [2:0] pos;
   irk_key_t   step_key;
   irk_key_t   acc_next;
   logic [2:0] cnt_sum;
   logic [6:0] seen_next;
   irk_addr_t  addr_dec;
   logic       restart;
   logic [7:0] gap_last;

   // ************************************************************
   // key decode of one scan step
   // ************************************************************
   function automatic irk_key_t key_decode(input logic [6:0] l, input logic [2:0] p);
      irk_key_t k;
      k = '0;
      if (l == PAIR_56_MASK) begin
         k.cnt  = 2'h1;
         k.code = {SENSE_PAIR_IDX, p};
      end else begin
         for (int i = 0; i < NLINES; i++) begin
            if (l[i]) begin
               k.cnt  = (k.cnt == 2'h0) ? 2'h1 : 2'h2;
               k.code = {3'(i), p};
            end
         end
      end
      return k;
   endfunction

   irk_addr_decode u_addr (
      .seen_i (seen_next),
      .addr_o (addr_dec)
   );

   // ************************************************************
   // scan step sampling
   // ************************************************************
   assign tick   = s_q.osc_en && (s_q.osc_div == OSC_DIV_LAST);
   assign active = ~key_sense_lines_n_i;
   // step 0 has no driver on: only sense lines tied to ground show
   assign pos    = (s_q.step == 3'h0) ? GND_POS : s_q.step - 3'h1;
   assign lines  = (s_q.step == 3'h0) ? active : (active & ~s_q.gnd_mask);
   assign step_key = key_decode(lines, pos);
   assign cnt_sum  = {1'b0, s_q.acc.cnt} + {1'b0, step_key.cnt};
   assign acc_next.cnt  = (cnt_sum >= 3'h2) ? 2'h2 : cnt_sum[1:0];
   assign acc_next.code = (step_key.cnt != 2'h0) ? step_key.code : s_q.acc.code;
   assign seen_next = (s_q.first_scan && s_q.step != 3'h0 && !address_mode_strap_i)
                    ? (s_q.strap_seen | (7'h01 << pos)) : s_q.strap_seen;
   assign gap_last  = s_q.multi ? GAP_FAST_LAST : GAP_SLOW_LAST;
   assign restart   = s_q.have_key && !s_q.multi;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_d = s_q;
      if (!s_q.osc_en || tick) begin
         s_d.osc_div = 8'h00;
      end else begin
         s_d.osc_div = s_q.osc_div + 8'h01;
      end

      unique case (s_q.phase)
         PH_STANDBY: begin
            s_d.drv_oe_n = '0;
            if (|active) begin
               s_d.phase    = PH_DEBOUNCE;
               s_d.osc_en   = 1'b1;
               s_d.strap_pd = 1'b0;
               s_d.strap_pu = 1'b1;
               s_d.cnt      = 8'h00;
            end
         end
         PH_DEBOUNCE: begin
            if (tick) begin
               if (s_q.cnt == DEBOUNCE_LAST) begin
                  s_d.cnt = 8'h00;
                  if (|active) begin
                     s_d.phase      = PH_SCAN;
                     s_d.step       = 3'h0;
                     s_d.first_scan = 1'b1;
                     s_d.strap_seen = '0;
                     s_d.acc        = '0;
                     s_d.gnd_mask   = '0;
                     s_d.rel_cnt    = '0;
                     s_d.drv_oe_n   = '1;
                  end else begin
                     s_d.phase    = PH_STANDBY;
                     s_d.osc_en   = 1'b0;
                     s_d.strap_pu = 1'b0;
                     s_d.strap_pd = 1'b1;
                     s_d.drv_oe_n = '0;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         PH_SCAN: begin
            if (tick) begin
               if (s_q.cnt == STEP_LAST) begin
                  s_d.cnt        = 8'h00;
                  s_d.acc        = acc_next;
                  s_d.strap_seen = seen_next;
                  if (s_q.step == 3'h0) begin
                     s_d.gnd_mask = active;
                  end
                  if (s_q.step == LAST_STEP) begin
                     s_d.phase    = PH_GAP;
                     s_d.drv_oe_n = '1;
                     s_d.acc      = '0;
                     if (s_q.first_scan) begin
                        s_d.addr       = addr_dec;
                        s_d.first_scan = 1'b0;
                     end
                     unique case (acc_next.cnt)
                        2'h0: begin
                           s_d.have_key = 1'b0;
                           s_d.multi    = 1'b0;
                        end
                        2'h1: begin
                           s_d.have_key = 1'b1;
                           s_d.key_code = acc_next.code;
                           s_d.multi    = 1'b0;
                        end
                        default: begin
                           s_d.have_key = 1'b0;
                           s_d.multi    = 1'b1;
                        end
                     endcase
                  end else begin
                     s_d.step     = s_q.step + 3'h1;
                     s_d.drv_oe_n = ~(7'h01 << s_q.step);
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         PH_GAP: begin
            if (tick) begin
               if (s_q.cnt >= gap_last) begin
                  s_d.cnt = 8'h00;
                  if (!s_q.have_key && !s_q.multi && !s_q.tx_on
                      && s_q.rel_cnt >= REL_TICKS) begin
                     s_d.toggle   = s_q.toggle + 2'h1;
                     s_d.phase    = PH_STANDBY;
                     s_d.osc_en   = 1'b0;
                     s_d.strap_pu = 1'b0;
                     s_d.strap_pd = 1'b1;
                     s_d.drv_oe_n = '0;
                  end else begin
                     s_d.phase    = PH_SCAN;
                     s_d.step     = 3'h0;
                     s_d.gnd_mask = '0;
                     s_d.acc      = '0;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
      endcase

      // release timing; multi-key strokes hold the toggles still
      if (s_q.have_key || s_q.multi) begin
         s_d.rel_cnt = '0;
      end else if (tick && s_q.rel_cnt < REL_TICKS) begin
         s_d.rel_cnt = s_q.rel_cnt + 12'h001;
      end

      // ************************************************************
      // word transmitter
      // ************************************************************
      if (tick) begin
         if (!s_q.tx_on) begin
            // only a freshly decoded single key starts a word, never the strap
            if (restart && s_q.phase != PH_STANDBY) begin
               s_d.tx_on    = 1'b1;
               s_d.word_cnt = '0;
               s_d.bit_idx  = 4'h0;
               s_d.tx_cnt   = '0;
               s_d.car_ph   = 4'h0;
               s_d.word_sh  = {s_q.addr.modulated ? 1'b1 : s_q.toggle[1],
                               s_q.toggle[0], s_q.addr.sub, s_q.key_code};
            end
         end else begin
            s_d.word_cnt = s_q.word_cnt + 17'h00001;
            s_d.car_ph   = (s_q.car_ph == CARRIER_LAST) ? 4'h0 : s_q.car_ph + 4'h1;
            if (s_q.tx_cnt != TX_CNT_MAX) begin
               s_d.tx_cnt = s_q.tx_cnt + 12'h001;
            end
            if (s_q.bit_idx < FINAL_PULSE_IDX
                && s_q.tx_cnt == (s_q.word_sh[10] ? SPACE_ONE_LAST : SPACE_ZERO_LAST)) begin
               s_d.bit_idx = s_q.bit_idx + 4'h1;
               s_d.tx_cnt  = '0;
               s_d.car_ph  = 4'h0;
               s_d.word_sh = {s_q.word_sh[9:0], 1'b0};
            end
            if (s_q.word_cnt == WORD_TICKS - 17'h00001) begin
               if (restart) begin
                  s_d.word_cnt = '0;
                  s_d.bit_idx  = 4'h0;
                  s_d.tx_cnt   = '0;
                  s_d.car_ph   = 4'h0;
                  s_d.word_sh  = {s_q.addr.modulated ? 1'b1 : s_q.toggle[1],
                                  s_q.toggle[0], s_q.addr.sub, s_q.key_code};
               end else begin
                  s_d.tx_on = 1'b0;
               end
            end
         end
      end

      if (!s_d.tx_on) begin
         s_d.pulse_req = 1'b0;
      end else if (s_d.addr.modulated) begin
         s_d.pulse_req = (s_d.tx_cnt < BURST_TICKS) && (s_d.car_ph < CARRIER_HIGH);
      end else begin
         s_d.pulse_req = s_d.tx_cnt < FLASH_PULSE_TICKS;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_q <= ST_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   irk_lockup_guard #(
      .LIMIT (LOCKUP_CYCLES)
   ) u_guard (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .req_i   (s_q.pulse_req),
      .pulse_o (ir_pattern_out_o)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   assign scan_drive_lines_o      = s_q.drv_out;
   assign scan_drive_lines_oe_n_o = s_q.drv_oe_n;
   assign strap_pull_up_o         = s_q.strap_pu;
   assign strap_pull_down_o       = s_q.strap_pd;
   assign resonator_en_o          = s_q.osc_en;
   assign tx_busy_o               = s_q.tx_on;
   assign multi_key_o             = s_q.multi;

endmodule

// >>> irk_encoder_checker.sv
// irk_encoder_checker: port assertions for the infrared key encoder
`timescale 1ns/1ps
module irk_encoder_checker import irk_pkg::*; #(
   parameter logic [16:0] LOCKUP_CYCLES = 17'h007D0
) (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       nrst_i,
   // key matrix and strap
   input wire logic [6:0] key_sense_lines_n_i,
   input wire logic [6:0] scan_drive_lines_o,
   input wire logic [6:0] scan_drive_lines_oe_n_o,
   input wire logic       address_mode_strap_i,
   input wire logic       strap_pull_up_o,
   input wire logic       strap_pull_down_o,
   // output and status
   input wire logic       resonator_en_o,
   input wire logic       ir_pattern_out_o,
   input wire logic       tx_busy_o,
   input wire logic       multi_key_o
);
   logic [16:0] hi_q;
   logic [16:0] hi_d;

   // consecutive cycles the output has been high before this one
   always_comb hi_d = ir_pattern_out_o ? hi_q + 17'h00001 : 17'h00000;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hi_q <= 17'h00000;
      end else begin
         hi_q <= hi_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   AST_DRV_ZERO: assert property (scan_drive_lines_o == 7'h00)
      else $error("drive value not low");
   AST_STANDBY: assert property (!resonator_en_o |-> scan_drive_lines_oe_n_o == 7'h00)
      else $error("driver off in stand-by");
   AST_PULLS: assert property (strap_pull_up_o == resonator_en_o &&
         strap_pull_down_o != resonator_en_o)
      else $error("strap loads wrong");
   AST_WAKE: assert property ((!resonator_en_o && key_sense_lines_n_i != 7'h7F) |=>
         (resonator_en_o && strap_pull_up_o))
      else $error("no wake on key");
   AST_SCAN_STEP: assert property ((resonator_en_o && $past(resonator_en_o) &&
         $changed(scan_drive_lines_oe_n_o) &&
         $countones(~$past(scan_drive_lines_oe_n_o)) == 1 &&
         $past(scan_drive_lines_oe_n_o) != 7'h3F) |->
         (~scan_drive_lines_oe_n_o == (~$past(scan_drive_lines_oe_n_o)) << 1))
      else $error("scan order broken");
   AST_NO_MULTI_START: assert property ($rose(tx_busy_o) |-> !multi_key_o)
      else $error("word started on several keys");
   AST_FIRST_PULSE: assert property ($rose(tx_busy_o) |=> $rose(ir_pattern_out_o))
      else $error("word without leading pulse");
   AST_LOCKUP: assert property (ir_pattern_out_o |-> hi_q < LOCKUP_CYCLES)
      else $error("output pulse too long");
   AST_PULSE_WIDTH: assert property ($fell(ir_pattern_out_o) |->
         hi_q == 17'(int'(CARRIER_HIGH) * OSC_DIV))
      else $error("pulse width wrong");
endmodule

bind irk_encoder irk_encoder_checker #(.LOCKUP_CYCLES(LOCKUP_CYCLES)) i_checker (
   .clk_i                  (clk_i),
   .nrst_i                 (nrst_i),
   .key_sense_lines_n_i    (key_sense_lines_n_i),
   .scan_drive_lines_o     (scan_drive_lines_o),
   .scan_drive_lines_oe_n_o(scan_drive_lines_oe_n_o),
   .address_mode_strap_i   (address_mode_strap_i),
   .strap_pull_up_o        (strap_pull_up_o),
   .strap_pull_down_o      (strap_pull_down_o),
   .resonator_en_o         (resonator_en_o),
   .ir_pattern_out_o       (ir_pattern_out_o),
   .tx_busy_o              (tx_busy_o),
   .multi_key_o            (multi_key_o)
);

// >>> irk_matrix_model.sv
// irk_matrix_model: key matrix, pair diodes and strap wiring around the encoder
`timescale 1ns/1ps
module irk_matrix_model (
   // clock
   input  wire logic            clk_i,
   // encoder side
   input  wire logic [6:0]      oe_n_i,
   input  wire logic            pull_up_i,
   input  wire logic            pull_down_i,
   output logic [6:0]           sense_n_o,
   output logic                 strap_o,
   // wiring: press_i[s][7] grounds sense line s
   input  wire logic [6:0][7:0] press_i,
   input  wire logic [6:0]      strap_conn_i
);
   logic float_q = 1'b0;

   // an unloaded strap wanders every cycle
   always_ff @(posedge clk_i) float_q <= ~float_q;

   always_comb begin
      for (int s = 0; s < 7; s++) begin
         sense_n_o[s] = ~(press_i[s][7] | (|(press_i[s][6:0] & ~oe_n_i)));
      end
      strap_o = (|(strap_conn_i & ~oe_n_i)) ? 1'b0 :
                (pull_up_i === 1'b1) ? 1'b1 : (pull_down_i === 1'b1) ? 1'b0 : float_q;
   end
endmodule

// >>> irk_encoder_test.sv
// irk_encoder_test: self-checking bench for the infrared key encoder
`timescale 1ns/1ps
module irk_encoder_test import irk_pkg::*;;
   logic            clk_i = 1'b0;
   logic            nrst_i = 1'b0;
   logic [6:0]      sense_n;
   logic [6:0]      oe_n;
   logic            strap;
   logic            pu;
   logic            pd;
   logic            res_en;
   logic            ir;
   logic            busy;
   logic            multi;
   logic [6:0][7:0] press = '0;
   logic [6:0][7:0] p;
   logic [6:0]      conn = 7'h00;
   int              seed = 79;
   int              bad_count = 0;
   int              compares = 0;
   int              n;
   int              m;
   int              s;

   initial forever #5 clk_i = ~clk_i;

   irk_matrix_model i_matrix (.clk_i(clk_i), .oe_n_i(oe_n), .pull_up_i(pu), .pull_down_i(pd),
      .sense_n_o(sense_n), .strap_o(strap), .press_i(press), .strap_conn_i(conn));

   irk_encoder #(.WORD_TICKS(17'h094D4), .LOCKUP_CYCLES(17'h007D0)) i_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .key_sense_lines_n_i(sense_n),
      .scan_drive_lines_o(), .scan_drive_lines_oe_n_o(oe_n),
      .address_mode_strap_i(strap), .strap_pull_up_o(pu), .strap_pull_down_o(pd),
      .resonator_en_o(res_en), .ir_pattern_out_o(ir), .tx_busy_o(busy), .multi_key_o(multi));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
                        input int tol);
      compares++;
      if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
         bad_count++;
         $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   function automatic logic cond(input int sel);
      case (sel)
         0: return busy;
         1: return ir;
         2: return oe_n == 7'h7E;
         3: return multi;
         4: return oe_n != 7'h7E;
         5: return !res_en;
         6: return res_en;
         default: return !ir;
      endcase
   endfunction

   task automatic wait_for(input int sel, input int lim, output int cnt);
      cnt = 0;
      while (cond(sel) !== 1'b1) begin
         @(negedge clk_i);
         cnt++;
         if (cnt > lim) begin
            bad_count++;
            $display("wrong value wait %0d: expected done, seen timeout", sel);
            give_verdict();
         end
      end
   endtask

   function automatic int scan_period(input logic fast);
      return ((int'(STEP_LAST) + 1) * 8 + int'(fast ? GAP_FAST_LAST : GAP_SLOW_LAST) + 1)
             * OSC_DIV;
   endfunction

   function automatic int next_rise(input logic [6:0] c);
      return c[MODE_LINE] ? (int'(CARRIER_LAST) + 1 - int'(CARRIER_HIGH)) * OSC_DIV : 3000;
   endfunction

   task automatic do_reset();
      @(posedge clk_i);
      nrst_i <= 1'b0;
      press <= '0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(negedge clk_i);
   endtask

   task automatic run_word(input logic [6:0][7:0] k, input logic [6:0] c);
      int t;
      do_reset();
      @(posedge clk_i);
      press <= k;
      conn <= c;
      wait_for(6, 10, t);
      check("strap pulls active", 2'b10, {pu, pd}, 0);
      wait_for(2, 6000, t);
      check("first drive", (int'(DEBOUNCE_LAST) + int'(STEP_LAST) + 2) * OSC_DIV, t, OSC_DIV);
      wait_for(0, 30000, t);
      check("multi at start", 0, multi, 0);
      wait_for(1, 5, t);
      wait_for(7, 2000, t);
      check("pulse width", int'(FLASH_PULSE_TICKS) * OSC_DIV, t, 0);
      t = 0;
      while (ir !== 1'b1 && t < 3000) begin
         @(negedge clk_i);
         t++;
      end
      check("next rise", next_rise(c), t, 1);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      do_reset();
      check("drive enables", 7'h00, oe_n, 0);
      check("strap pulls idle", 2'b01, {pu, pd}, 0);
      @(posedge clk_i);
      conn <= 7'h7F;
      repeat (100) @(negedge clk_i);
      check("wake on strap", 0, res_en, 0);
      @(posedge clk_i);
      press[3][7] <= 1'b1;
      repeat (500) @(posedge clk_i);
      press[3][7] <= 1'b0;
      wait_for(5, 5000, n);
      check("busy after bounce", 0, busy, 0);
      // grounded line plus a second key on it, open strap
      p = '0;
      s = $unsigned($random(seed)) % 7;
      p[s][7] = 1'b1;
      p[s][$unsigned($random(seed)) % 7] = 1'b1;
      run_word(p, 7'h00);
      // diode pair on one drive line, modulated strap
      p = '0;
      s = $unsigned($random(seed)) % 7;
      p[5][s] = 1'b1;
      p[6][s] = 1'b1;
      run_word(p, {1'b1, 6'($random(seed))});
      // two keys on different sense lines
      do_reset();
      p = '0;
      p[$unsigned($random(seed)) % 4][$unsigned($random(seed)) % 7] = 1'b1;
      p[4][$unsigned($random(seed)) % 7] = 1'b1;
      @(posedge clk_i);
      press <= p;
      wait_for(3, 20000, n);
      check("busy on multi", 0, busy, 0);
      wait_for(2, 10000, n);
      wait_for(4, 2000, n);
      wait_for(2, 10000, m);
      check("fast scan period", scan_period(1'b1), n + m, OSC_DIV);
      check("busy on multi", 0, busy, 0);
      give_verdict();
   end
endmodule
